/* File: pmr_pkg.sv */
// Shared constants and types for the PSE mask and restart control block.
// Assumes a single 125 MHz clock domain inside the device.
package pmr_pkg;

    // Port counts: eight ports, seen as two halves of four
    localparam int NPORT = 8;
    localparam int HALF  = 4;
    // Width of a detection or classification result code
    localparam int RES_W = 4;

    // Command codes on the serial register bus
    localparam logic [7:0] CMD_CFG = 8'h17;
    localparam logic [7:0] CMD_RST = 8'h18;

    // General configuration register reset value and bit positions
    localparam logic [7:0] CFG_RESET = 8'h80;
    localparam int B_GATE = 7;
    localparam int B_WIDE = 5;
    localparam int B_MPRI = 4;
    localparam int B_CCHG = 3;
    localparam int B_DCHG = 2;
    // Class restart bits sit above the detect restart bits
    localparam int CLS_LSB = 4;

    // Bit counter width and full-byte count
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_ACKA  = 4'b0010,
        ST_CMD   = 4'b0011,
        ST_ACKC  = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_ACKW  = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_ACKR  = 4'b1000
    } pmr_state_t;

    // Per-port result array
    typedef logic [NPORT-1:0][RES_W-1:0] pmr_res_t;

endpackage

/* File: pmr_evt_if.sv */
// Event qualification carrier between the control block and a qualifier.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pmr_evt_if;
    import pmr_pkg::*;
    logic [NPORT-1:0] done;        // Cycle completed, per port
    pmr_res_t         result;      // Latest result, per port
    logic             change_only; // Flag only on a changed result
    logic [NPORT-1:0] set;         // Event flag set pulse, per port

    // Control side drives cycles, reads flag sets
    modport ctl (output done, output result, output change_only,
                 input set);
    // Qualifier side
    modport qual (input done, input result, input change_only,
                  output set);
endinterface
`default_nettype wire

/* File: pmr_pin_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module pmr_pin_sync
    import pmr_pkg::*;
#(
    parameter int W = 2
)(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output var  logic [W-1:0] pin_sync
);
    // First stage, read only by the second
    logic [W-1:0] meta_reg;
    // Second stage
    logic [W-1:0] sync_reg;

    // Two register stages, idle-high reset for bus pins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync = sync_reg;
endmodule
`default_nettype wire

/* File: pmr_evt_qual.sv */
// Per-port event qualifier: every cycle or change-only flagging.
// Assumes done pulses last one clock.
`timescale 1ns/1ps
`default_nettype none
module pmr_evt_qual
    import pmr_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    pmr_evt_if.qual   ev
);
    // Previous result per port
    logic [RES_W-1:0] prev_reg [NPORT];
    // Flag set pulses
    logic [NPORT-1:0] set_reg;
    logic [NPORT-1:0] set_next;

    // Qualify each completion against the stored result
    // change-only or every cycle
    always_comb
    begin
        for (int i = 0; i < NPORT; i++)
            set_next[i] = ev.done[i] &&
                (!ev.change_only || ev.result[i] != prev_reg[i]);
    end

    // Store results and issue pulses
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            set_reg <= '0;
            for (int i = 0; i < NPORT; i++)
                prev_reg[i] <= '0;
        end
        else
        begin
            set_reg <= set_next;
            for (int i = 0; i < NPORT; i++)
                if (ev.done[i])
                    prev_reg[i] <= ev.result[i];
        end
    end

    assign ev.set = set_reg;

    property p_every;
        @(posedge clock) disable iff (rst)
        (!ev.change_only && ev.done[0]) |=> ev.set[0];
    endproperty
    a_every: assert property (p_every)
        else $error("completion not flagged");

    property p_same;
        @(posedge clock) disable iff (rst)
        (ev.change_only && ev.done[1] && ev.result[1] == prev_reg[1])
            |=> !ev.set[1];
    endproperty
    a_same: assert property (p_same)
        else $error("unchanged result flagged");
endmodule
`default_nettype wire

/* File: pmr_top.sv */
// Mask and restart control: serial register slave, configuration
// register, restart strobes and event qualification.
// Assumes the sequencer, fault timers and event registers are outside.
//
// Overview of operation
// - Gate bit clear keeps interrupt pin inactive
// - Gate set: unmasked interrupt bit drives pin
// - Gate bit never touches event registers
// - Wide mode: one address, 16-bit access
// - Narrow mode: two addresses, 8-bit access
// - Multilevel set selects 3-bit priority
// - Multilevel clear selects 1-bit priority
// - Class change-only flags only changed class
// - Otherwise flag every classification
// - Detect change-only flags only changed detect
// - Otherwise flag every detection
// - Restart write: ones trigger, zeros ignored
// - Manual mode launches one cycle
// - Semiauto mode sets enable bit
// - Restart register reads zero
// - Cool-down defers restart until it ends
// - Bits 7-4 class, 3-0 detect
// - Configuration at command 17h, read/write
`timescale 1ns/1ps
`default_nettype none
module pmr_top
    import pmr_pkg::*;
#(
    // Base slave address; value is arbitrary
    parameter logic [6:0] SLV_BASE = 7'h20
)(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             scl,
    input  wire logic             sda_in,
    output var  logic             sda_out,
    output var  logic             sda_oe_n,
    input  wire logic [7:0]       irq_status,
    input  wire logic [7:0]       irq_mask,
    output var  logic             int_n,
    output var  logic [7:0]       cfg_value,
    output var  logic             wide_access_select,
    output var  logic             multilevel_priority_select,
    input  wire logic [NPORT-1:0] port_semiauto,
    input  wire logic [NPORT-1:0] port_cooldown,
    output var  logic [NPORT-1:0] det_cycle_start,
    output var  logic [NPORT-1:0] cls_cycle_start,
    output var  logic [NPORT-1:0] det_enable_set,
    output var  logic [NPORT-1:0] cls_enable_set,
    input  wire logic [NPORT-1:0] det_done,
    input  wire pmr_res_t         det_result,
    input  wire logic [NPORT-1:0] cls_done,
    input  wire pmr_res_t         cls_result,
    output var  logic [NPORT-1:0] detect_event_flag,
    output var  logic [NPORT-1:0] class_event_flag
);
    // Synchronised bus pins
    logic [1:0]       pins_sync;
    logic             scl_s;
    logic             sda_s;
    // Previous synchronised levels for edge finding
    logic             scl_prev_reg;
    logic             sda_prev_reg;
    // Bus edges and conditions
    logic             scl_rise;
    logic             scl_fall;
    logic             bus_start;
    logic             bus_stop;
    // Slave state machine
    pmr_state_t       st_reg;
    pmr_state_t       st_next;
    logic [3:0]       bit_cnt_reg;
    logic [7:0]       shift_reg;
    logic [7:0]       tx_reg;
    logic [7:0]       cmd_reg;
    logic             rw_reg;
    logic             half_reg;
    logic             byte_idx_reg;
    logic             drive_low_reg;
    // Decoded address
    logic [6:0]       addr_rx;
    logic             addr_hit;
    logic             addr_upper;
    // Register storage
    logic [7:0]       cfg_reg;
    logic             int_n_reg;
    // Write strobes
    logic             wr_byte;
    logic             wr_cfg;
    logic             wr_rst;
    logic             upper_half;
    logic [7:0]       rd_byte;
    // Restart requests and deferral
    logic [NPORT-1:0] det_req;
    logic [NPORT-1:0] cls_req;
    logic [NPORT-1:0] det_pend_reg;
    logic [NPORT-1:0] cls_pend_reg;
    logic [NPORT-1:0] det_fire;
    logic [NPORT-1:0] cls_fire;
    logic [NPORT-1:0] det_start_reg;
    logic [NPORT-1:0] cls_start_reg;
    logic [NPORT-1:0] det_ens_reg;
    logic [NPORT-1:0] cls_ens_reg;

    // Spread a four-port nibble onto the addressed half
    function automatic logic [NPORT-1:0] spread(
        input logic [HALF-1:0] nib,
        input logic            up
    );
        spread = up ? {nib, {HALF{1'b0}}} : {{HALF{1'b0}}, nib};
    endfunction

    // Pin synchroniser for clock and data lines
    pmr_pin_sync #(.W(2)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .pin      ({scl, sda_in}),
        .pin_sync (pins_sync)
    );
    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // Edge history
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    // Edge and condition decode
    assign scl_rise  = scl_s && !scl_prev_reg;
    assign scl_fall  = !scl_s && scl_prev_reg;
    assign bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign bus_stop  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // Address decode
    // upper address answers only in narrow mode
    assign addr_rx    = shift_reg[7:1];
    assign addr_upper = !cfg_reg[B_WIDE] &&
                        addr_rx == SLV_BASE + 7'h01;
    assign addr_hit   = addr_rx == SLV_BASE || addr_upper;

    // Write decode at each received data byte
    assign wr_byte    = st_reg == ST_WDATA && scl_fall &&
                        bit_cnt_reg == BYTE_BITS;
    // second byte of a wide access reaches ports 5-8
    assign upper_half = cfg_reg[B_WIDE] ? byte_idx_reg : half_reg;
    assign wr_cfg = wr_byte && cmd_reg == CMD_CFG &&
                    !(cfg_reg[B_WIDE] && byte_idx_reg);
    assign wr_rst = wr_byte && cmd_reg == CMD_RST;

    // Read data: restart and unmapped commands read zero
    // restart register returns zero
    assign rd_byte = cmd_reg == CMD_CFG ? cfg_reg : 8'h00;

    // upper nibble class, lower nibble detect
    assign det_req = wr_rst ?
        spread(shift_reg[HALF-1:0], upper_half) : '0;
    assign cls_req = wr_rst ?
        spread(shift_reg[CLS_LSB +: HALF], upper_half) : '0;

    // Slave next state
    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE:  st_next = ST_IDLE;
            ST_ADDR:
                if (scl_fall && bit_cnt_reg == BYTE_BITS)
                    st_next = addr_hit ? ST_ACKA : ST_IDLE;
            ST_ACKA:
                if (scl_fall)
                    st_next = rw_reg ? ST_RDATA : ST_CMD;
            ST_CMD:
                if (scl_fall && bit_cnt_reg == BYTE_BITS)
                    st_next = ST_ACKC;
            ST_ACKC:
                if (scl_fall)
                    st_next = ST_WDATA;
            ST_WDATA:
                if (scl_fall && bit_cnt_reg == BYTE_BITS)
                    st_next = ST_ACKW;
            ST_ACKW:
                if (scl_fall)
                    st_next = ST_WDATA;
            ST_RDATA:
                if (scl_fall && bit_cnt_reg == BYTE_BITS)
                    st_next = ST_ACKR;
            ST_ACKR:
                if (scl_fall)
                    st_next = rw_reg ? ST_RDATA : ST_IDLE;
            default:  st_next = ST_IDLE;
        endcase
        if (bus_stop)
            st_next = ST_IDLE;
        if (bus_start)
            st_next = ST_ADDR;
    end

    // Slave state and bit counter
    always_ff @(posedge clock)
    begin
        if (rst)
            st_reg <= ST_IDLE;
        else
            st_reg <= st_next;
    end

    always_ff @(posedge clock)
    begin
        if (rst || bus_start || (scl_fall && bit_cnt_reg == BYTE_BITS))
            bit_cnt_reg <= '0;
        else if (scl_rise && bit_cnt_reg != BYTE_BITS &&
                 st_reg inside {ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA})
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end

    // Receive shifter, sampled on the clock line rising
    always_ff @(posedge clock)
    begin
        if (rst)
            shift_reg <= '0;
        else if (scl_rise && bit_cnt_reg != BYTE_BITS)
            shift_reg <= {shift_reg[6:0], sda_s};
    end

    // Address, command and byte position capture
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rw_reg       <= 1'b0;
            half_reg     <= 1'b0;
            cmd_reg      <= '0;
            byte_idx_reg <= 1'b0;
        end
        else if (st_reg == ST_ADDR && st_next == ST_ACKA)
        begin
            rw_reg       <= shift_reg[0];
            half_reg     <= addr_upper;
            byte_idx_reg <= 1'b0;
        end
        else if (st_reg == ST_CMD && st_next == ST_ACKC)
            cmd_reg <= shift_reg;
        else if (st_reg == ST_ACKR && scl_rise)
            // Master refusal in the ack slot ends the read
            rw_reg <= !sda_s;
        else if (st_reg == ST_ACKR && scl_fall)
            byte_idx_reg <= !byte_idx_reg;
        else if (st_reg == ST_ACKW && scl_fall)
            byte_idx_reg <= !byte_idx_reg;
    end

    // Transmit shifter and open-drain drive
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_reg        <= '0;
            drive_low_reg <= 1'b0;
        end
        else if (bus_start || bus_stop)
            drive_low_reg <= 1'b0;
        else if (scl_fall)
        begin
            unique case (st_next)
                // Acknowledge each received byte by pulling low
                ST_ACKA, ST_ACKC, ST_ACKW:
                    drive_low_reg <= 1'b1;
                ST_RDATA:
                begin
                    if (st_reg == ST_RDATA)
                    begin
                        tx_reg        <= {tx_reg[6:0], 1'b0};
                        drive_low_reg <= !tx_reg[6];
                    end
                    else
                    begin
                        tx_reg        <= rd_byte;
                        drive_low_reg <= !rd_byte[7];
                    end
                end
                default:
                    drive_low_reg <= 1'b0;
            endcase
        end
    end

    // Open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drive_low_reg;

    // Configuration register
    // reserved bits are plain storage
    always_ff @(posedge clock)
    begin
        if (rst)
            cfg_reg <= CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= shift_reg;
    end

    // Interrupt pin from outside event logic, never written back
    // gate only the pin
    always_ff @(posedge clock)
    begin
        if (rst)
            int_n_reg <= 1'b1;
        else
            int_n_reg <= !(cfg_reg[B_GATE] &&
                           |(irq_status & irq_mask));
    end
    assign int_n = int_n_reg;

    // Configuration outputs toward the rest of the device
    // priority scheme select
    assign multilevel_priority_select = cfg_reg[B_MPRI];
    assign wide_access_select         = cfg_reg[B_WIDE];
    assign cfg_value                  = cfg_reg;

    // requests wait while the port cools down
    assign det_fire = (det_req | det_pend_reg) & ~port_cooldown;
    assign cls_fire = (cls_req | cls_pend_reg) & ~port_cooldown;

    // Deferred restarts and single-cycle outputs
    // manual start or semiauto enable
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            det_pend_reg  <= '0;
            cls_pend_reg  <= '0;
            det_start_reg <= '0;
            cls_start_reg <= '0;
            det_ens_reg   <= '0;
            cls_ens_reg   <= '0;
        end
        else
        begin
            det_pend_reg  <= (det_req | det_pend_reg) & port_cooldown;
            cls_pend_reg  <= (cls_req | cls_pend_reg) & port_cooldown;
            det_start_reg <= det_fire & ~port_semiauto;
            cls_start_reg <= cls_fire & ~port_semiauto;
            det_ens_reg   <= det_fire & port_semiauto;
            cls_ens_reg   <= cls_fire & port_semiauto;
        end
    end
    assign det_cycle_start = det_start_reg;
    assign cls_cycle_start = cls_start_reg;
    assign det_enable_set  = det_ens_reg;
    assign cls_enable_set  = cls_ens_reg;

    // Event qualifiers for detection and classification
    pmr_evt_if det_ev ();
    pmr_evt_if cls_ev ();
    assign det_ev.done        = det_done;
    assign det_ev.result      = det_result;
    assign det_ev.change_only = cfg_reg[B_DCHG];
    assign cls_ev.done        = cls_done;
    assign cls_ev.result      = cls_result;
    assign cls_ev.change_only = cfg_reg[B_CCHG];
    assign detect_event_flag  = det_ev.set;
    assign class_event_flag   = cls_ev.set;

    pmr_evt_qual u_det_q (
        .clock (clock),
        .rst   (rst),
        .ev    (det_ev)
    );
    pmr_evt_qual u_cls_q (
        .clock (clock),
        .rst   (rst),
        .ev    (cls_ev)
    );

    property p_gate_off;
        @(posedge clock) disable iff (rst)
        !cfg_reg[B_GATE] |=> int_n;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("interrupt pin active while gated");

    property p_gate_on;
        @(posedge clock) disable iff (rst)
        (cfg_reg[B_GATE] && |(irq_status & irq_mask)) |=> !int_n;
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("unmasked interrupt not signalled");

    property p_wide_one;
        @(posedge clock) disable iff (rst)
        (st_reg == ST_ACKA && cfg_reg[B_WIDE]) |-> !half_reg;
    endproperty
    a_wide_one: assert property (p_wide_one)
        else $error("upper address answered in wide mode");

    property p_rd_zero;
        @(posedge clock) disable iff (rst)
        (scl_fall && st_reg == ST_ACKA && rw_reg &&
         cmd_reg == CMD_RST) |=> (tx_reg == 8'h00);
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("restart register read not zero");

    property p_manual;
        @(posedge clock) disable iff (rst)
        (det_req[0] && !port_cooldown[0] && !port_semiauto[0])
            |=> det_cycle_start[0] ##1 !det_cycle_start[0];
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual restart not a single strobe");

    property p_semi;
        @(posedge clock) disable iff (rst)
        (cls_req[1] && !port_cooldown[1] && port_semiauto[1])
            |=> cls_enable_set[1] && !cls_cycle_start[1];
    endproperty
    a_semi: assert property (p_semi)
        else $error("semiauto restart did not set enable");

    property p_hold;
        @(posedge clock) disable iff (rst)
        port_cooldown[2] |=> !det_cycle_start[2] && !det_enable_set[2];
    endproperty
    a_hold: assert property (p_hold)
        else $error("restart acted during cool-down");

    property p_release;
        @(posedge clock) disable iff (rst)
        (det_pend_reg[2] && !port_cooldown[2])
            |=> (det_cycle_start[2] || det_enable_set[2]);
    endproperty
    a_release: assert property (p_release)
        else $error("deferred restart lost");

    property p_cfg_rst;
        @(posedge clock) rst |=> cfg_reg == CFG_RESET;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst)
        else $error("configuration reset value wrong");

    c_cfg_wr:  cover property (@(posedge clock) wr_cfg);
    c_rst_wr:  cover property (@(posedge clock) wr_rst);
    c_defer:   cover property (@(posedge clock)
                   det_pend_reg[0] ##1 !det_pend_reg[0]);
    c_rd_byte: cover property (@(posedge clock)
                   st_reg == ST_RDATA && scl_fall);
endmodule
`default_nettype wire

/* File: pmr_host.sv */
// Host model: serial register bus master with an open-drain data line.
// Assumes the bench resolves the pulled-up data wire from all drivers.
`timescale 1ns/1ps
`default_nettype none
module pmr_host (
    output var logic scl,
    output var logic sda_m,
    input  wire logic sda
);
    int nacks; // Bytes the slave left unacknowledged

    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
        nacks = 0;
    end

    // One bit: data set while clock low, sampled late in high phase
    task automatic bit_x(input logic b, output logic s);
        sda_m = b;
        #16 scl = 1'b1;
        #28 s = sda;
        #4 scl = 1'b0;
        #16;
    endtask

    // Start or repeated start: data falls while clock is high
    task automatic start_c();
        sda_m = 1'b1;
        #16 scl = 1'b1;
        #16 sda_m = 1'b0;
        #16 scl = 1'b0;
        #16;
    endtask

    // Stop: data rises while clock is high, bus left idle
    task automatic stop_c();
        sda_m = 1'b0;
        #16 scl = 1'b1;
        #16 sda_m = 1'b1;
        #32;
    endtask

    // Byte plus acknowledge bit; chk counts a missing slave ack
    task automatic byte_x(input logic [7:0] d, input logic last,
                          input logic chk, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(last, a);
        if (chk && a !== 1'b0)
            nacks++;
    endtask

    // Register write of n data bytes, low byte first
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input int n, input logic [15:0] d);
        logic [7:0] q;
        start_c();
        byte_x({a, 1'b0}, 1'b1, 1'b1, q);
        byte_x(c, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++)
            byte_x(d[8*i+:8], 1'b1, 1'b1, q);
        stop_c();
    endtask

    // Register read of one byte, ended by master NACK
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] c,
                          output logic [7:0] v);
        logic [7:0] q;
        start_c();
        byte_x({a, 1'b0}, 1'b1, 1'b1, q);
        byte_x(c, 1'b1, 1'b1, q);
        start_c();
        byte_x({a, 1'b1}, 1'b1, 1'b1, q);
        byte_x(8'hff, 1'b1, 1'b0, v);
        stop_c();
    endtask
endmodule
`default_nettype wire

/* File: pmr_top_tb.sv */
// Bench for the mask and restart control block with a reference model.
// Assumes pmr_host masters the serial bus at a 64 ns bit period.
`timescale 1ns/1ps
`default_nettype none
module pmr_top_tb;
    import pmr_pkg::*;
    localparam logic [6:0] BASE = 7'h20; // Arbitrary address
    logic clock = 0, rst = 1, scl, sda_m, sda_out, sda_oe_n, int_n;
    logic [7:0] irq_status = 0, irq_mask = 0, cfg_value, cfg_m = 8'h80;
    logic wide_access_select, multilevel_priority_select;
    logic [7:0] port_semiauto = 0, port_cooldown = 0, det_done = 0;
    logic [7:0] det_cycle_start, cls_cycle_start, det_enable_set;
    logic [7:0] cls_enable_set, cls_done = 0;
    logic [7:0] detect_event_flag, class_event_flag;
    pmr_res_t det_result = '0, cls_result = '0;
    logic [31:0] seen = 0;
    logic [15:0] fl = 0;
    int np = 0, mismatches = 0, total_checks = 0, pd[8], pc[8];
    wire logic sda = sda_m & (sda_oe_n | sda_out); // Pulled-up line
    wire logic [31:0] pul = {cls_enable_set, cls_cycle_start,
                             det_enable_set, det_cycle_start};

    pmr_top #(.SLV_BASE(BASE)) pmr_top_inst (.clock, .rst, .scl,
        .sda_in(sda), .sda_out, .sda_oe_n, .irq_status, .irq_mask,
        .int_n, .cfg_value, .wide_access_select,
        .multilevel_priority_select, .port_semiauto, .port_cooldown,
        .det_cycle_start, .cls_cycle_start, .det_enable_set,
        .cls_enable_set, .det_done, .det_result, .cls_done,
        .cls_result, .detect_event_flag, .class_event_flag);
    pmr_host host_inst (.scl(scl), .sda_m(sda_m), .sda(sda));

    always #4 clock = ~clock;
    // Gathers strobes and flags seen since the last clear
    always @(posedge clock)
    begin
        seen <= seen | pul;
        np <= np + $countones(pul);
        fl <= fl | {class_event_flag, detect_event_flag};
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Expected strobes of one half: low nibble detect, high nibble class
    function automatic logic [31:0] expv(input int h, input logic [7:0] d);
        logic [31:0] v;
        v = 0;
        for (int k = 0; k < 4; k++)
        begin
            v[(port_semiauto[h*4+k] ? 8 : 0) + h*4 + k] |= d[k];
            v[(port_semiauto[h*4+k] ? 24 : 16) + h*4 + k] |= d[k+4];
        end
        return v;
    endfunction

    // Restart write with random modes and cool-downs, then release
    task automatic restart(input int h, input int w, input logic [15:0] d);
        logic [31:0] e;
        port_cooldown = 8'($urandom);
        port_semiauto = 8'($urandom);
        seen = 0;
        np = 0;
        e = w ? expv(0, d[7:0]) | expv(1, d[15:8]) : expv(h, d[7:0]);
        host_inst.wr(BASE + 7'(h), CMD_RST, w ? 2 : 1, d);
        repeat (6) @(posedge clock);
        #1;
        chk("held", e & {4{~port_cooldown}}, seen);
        port_cooldown = 0;
        repeat (4) @(posedge clock);
        #1;
        chk("restart", e, seen);
        chk("pulses", $countones(e), np);
    endtask

    task automatic intr();
        irq_status = 8'($urandom);
        irq_mask = 8'($urandom);
        repeat (2) @(posedge clock);
        #1;
        chk("int_n", !(cfg_m[7] && |(irq_status & irq_mask)), int_n);
    endtask

    // Random done pulses against every-cycle or change-only flagging
    task automatic evt();
        int p;
        logic [3:0] rd, rc;
        logic [15:0] e;
        for (int i = 0; i < 8; i++)
        begin
            p = $urandom_range(7);
            rd = 4'($urandom_range(1));
            rc = 4'($urandom_range(1));
            e = 0;
            e[p] = !cfg_m[2] || rd != pd[p];
            e[8+p] = !cfg_m[3] || rc != pc[p];
            pd[p] = rd;
            pc[p] = rc;
            fl = 0;
            det_done[p] = 1'b1;
            cls_done[p] = 1'b1;
            det_result[p] = rd;
            cls_result[p] = rc;
            @(posedge clock);
            #1;
            det_done = 0;
            cls_done = 0;
            repeat (3) @(posedge clock);
            #1;
            chk("event", e, fl);
        end
    endtask

    task automatic setcfg(input logic [7:0] v);
        logic [7:0] q;
        // fast shutdown input is not modelled; treated as idle
        host_inst.wr(BASE, CMD_CFG, 1, {8'h00, v});
        cfg_m = v;
        host_inst.rd_reg(BASE, CMD_CFG, q);
        chk("cfg", v, q);
        chk("cfg_value", v, cfg_value);
        chk("modes", v[5:4], {wide_access_select,
            multilevel_priority_select});
    endtask

    initial
    begin
        logic [7:0] q;
        q = 8'($urandom(32'h89ccad2c));
        repeat (16) @(posedge clock);
        #1;
        rst = 0;
        repeat (4) @(posedge clock);
        host_inst.rd_reg(BASE, CMD_CFG, q);
        chk("cfg reset", 8'h80, q);
        intr();
        for (int i = 0; i < 4; i++)
            restart(i % 2, 0, 16'($urandom));
        host_inst.rd_reg(BASE, CMD_RST, q);
        chk("restart read", 0, q);
        evt();
        for (int i = 0; i < 5; i++)
        begin
            setcfg(8'($urandom) & 8'hdf);
            intr();
            evt();
            restart(1, 0, 16'($urandom));
        end
        setcfg(8'ha0);
        chk("acks", 0, host_inst.nacks);
        host_inst.wr(BASE + 7'h1, CMD_RST, 1, 16'h00ff);
        chk("nacks", 3, host_inst.nacks);
        restart(0, 1, 16'($urandom));
        test_done();
    end

    // Cuts a hang short
    initial
    begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
